// *** src/trs_defines.svh ***
// Constants of the timing reference selector: offsets, fields, resets, timing.
// Assumes a 32-bit APB register bus and a 100 MHz core clock.
`ifndef TRS_DEFINES_SVH
`define TRS_DEFINES_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define TRS_CTRL_OFS 8'h00
`define TRS_ROUTE_OFS 8'h04
`define TRS_LIMIT_OFS 8'h08
`define TRS_STAT_OFS 8'h0C
`define TRS_FLAG_OFS 8'h10
`define TRS_PHASE_OFS 8'h14
`define TRS_PBO_OFS 8'h18
`define TRS_INCFG_OFS 8'h20
// ----------------------------------------
// Fields and limits
// ----------------------------------------
`define TRS_FLAG_FAIL_BIT 16
`define TRS_T0_BW_MAX 5'd20
`define TRS_T4_BW_MAX 2'd2
`define TRS_CTRL_RST 32'h0000_0000
`define TRS_ROUTE_RST 32'h0000_0000
`define TRS_LIMIT_RST 32'h0004_0010
`define TRS_INCFG_MON_RST 2'b01
// ----------------------------------------
// Timing
// ----------------------------------------
`define TRS_CLK_PERIOD_NS 10
`define TRS_FS_PERIOD_NS 125000
`define TRS_WIN_NS 10000
`define TRS_MF_PER_FS 4
`endif

// *** src/trs_pkg.sv ***
// Types shared by the timing reference selector.
// Assumes trs_defines.svh supplies the numeric constants.
package trs_pkg;
  // Primary path lock state, one-hot
  typedef enum logic [2:0] {
    TRS_FREE = 3'b001,
    TRS_LOCKED = 3'b010,
    TRS_HOLD = 3'b100
  } trs_t0_state_type;
  // Auxiliary path state, one-hot
  typedef enum logic [1:0] {
    TRS_AUX_IDLE = 2'b01,
    TRS_AUX_LOCK = 2'b10
  } trs_t4_state_type;
  // Per-input configuration word
  typedef struct packed {
    logic [15:0] expect_cnt;
    logic [5:0] spare;
    logic freq_mon;
    logic act_mon;
    logic [3:0] pri_aux;
    logic [3:0] pri_prim;
  } trs_incfg_type;
endpackage

// *** src/trs_top.sv ***
// Reference monitor, selector and path control of a dual-path timing device.
// Assumes synchronous APB master on CLK; clock inputs are asynchronous pins.
// Operation
// - Monitor each input for activity and frequency.
// - Beyond hard limit the input is invalid.
// - Beyond soft limit only warns, stays valid.
// - Priority zero marks input unavailable.
// - Separate priority sets per path.
// - Each path picks best valid input.
// - Reference failure follows selected input state.
// - Primary path free-run/locked/holdover, manual override.
// - Auxiliary state machine, not software commanded.
// - Manual forcing overrides automatic choice.
// - Primary nonrevertive option keeps current reference.
// - Phase build-out on switches and hits.
// - Primary bandwidth 21 settings.
// - Auxiliary bandwidth three settings.
// - Auxiliary phase difference measurement mode.
// - Same-path outputs fall together at 2kHz.
// - Seven synth engines assignable to either path.
// - Aux multiplier switchable, primary ones fixed.
// - Primary outputs aligned to chosen sync input.
// - Bypass routes divided aux reference out.
// - Frame sync 8kHz, multiframe 2kHz.
// - Failure pin mirrors flag when enabled.
//
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "trs_defines.svh"
module trs_top #(
  parameter int FS_CYC = `TRS_FS_PERIOD_NS / `TRS_CLK_PERIOD_NS,
  parameter int WIN_CYC = `TRS_WIN_NS / `TRS_CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Reference clocks and frame-sync inputs
  input wire logic [7:0] IN_CLK,
  input wire logic [2:0] SYNC_IN,
  // Failure pin, three-state
  output logic REF_FAIL_O,
  output logic REF_FAIL_OE,
  // Frame outputs
  output logic FRAME_SYNC_OUT,
  output logic MULTIFRAME_SYNC_OUT,
  // Synthesizer routing and loop settings
  output logic [6:0] ENGINE_PATH,
  output logic AUX_MULT_PATH,
  output logic [6:0] BYPASS_EN,
  output logic BYPASS_CLK,
  output logic [4:0] T0_BW,
  output logic [1:0] T4_BW,
  output logic PBO_PULSE
);
  localparam int NIN = 8;
  // ----------------------------------------
  // Registers and decode
  // ----------------------------------------
  logic [31:0] ctrl_reg, route_reg, limit_reg;
  trs_pkg::trs_incfg_type cfg_reg [NIN];
  logic fail_flag_reg;
  logic [15:0] pbo_cnt_reg;
  logic [23:0] ph_val_reg;
  logic wr, acc, hit;
  logic fail_set;
  assign acc = PSEL & PENABLE;
  assign wr = acc & PWRITE;
  assign PREADY = 1'b1;
  assign hit = (PADDR[7:5] == 3'b001) || (PADDR <= `TRS_PBO_OFS && PADDR[1:0] == 2'b00);
  assign PSLVERR = acc & ~hit;
  // Control fields
  logic [2:0] t0_force_sel, t4_force_sel, meas_a, meas_b;
  logic t0_force_en, t4_force_en, nonrev, t0_man_en, pin_en, meas_en;
  logic [1:0] t0_man_code, sync_sel, sync_rate;
  assign t0_force_sel = ctrl_reg[2:0];
  assign t0_force_en = ctrl_reg[3];
  assign t4_force_sel = ctrl_reg[6:4];
  assign t4_force_en = ctrl_reg[7];
  assign nonrev = ctrl_reg[8];
  assign t0_man_en = ctrl_reg[9];
  assign t0_man_code = ctrl_reg[11:10];
  assign pin_en = ctrl_reg[19];
  assign meas_en = ctrl_reg[20];
  assign meas_a = ctrl_reg[23:21];
  assign meas_b = ctrl_reg[26:24];
  assign sync_sel = route_reg[16:15];
  assign sync_rate = route_reg[18:17];
  // Register writes; the failure flag sits below with its own set path
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctrl_reg <= `TRS_CTRL_RST;
      route_reg <= `TRS_ROUTE_RST;
      limit_reg <= `TRS_LIMIT_RST;
      for (int i = 0; i < NIN; i++) begin
        cfg_reg[i] <= {16'h0000, 6'h00, `TRS_INCFG_MON_RST, 4'(i + 1), 4'(i + 1)};
      end
    end else if (wr) begin
      if (PADDR == `TRS_CTRL_OFS) begin
        ctrl_reg <= PWDATA;
      end else if (PADDR == `TRS_ROUTE_OFS) begin
        route_reg <= PWDATA;
      end else if (PADDR == `TRS_LIMIT_OFS) begin
        limit_reg <= PWDATA;
      end else if (PADDR[7:5] == 3'b001) begin
        cfg_reg[PADDR[4:2]] <= PWDATA;
      end
    end
  end
  // ----------------------------------------
  // Input monitors
  // ----------------------------------------
  logic [NIN-1:0] in_m_reg, in_s_reg, in_d_reg, in_rise;
  logic [15:0] win_cnt_reg;
  logic win_end;
  logic [15:0] edge_cnt_reg [NIN];
  logic [NIN-1:0] active_reg, hard_reg, soft_reg, valid;
  // Two-stage synchroniser, then one delay for edge detect
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      in_m_reg <= '0;
      in_s_reg <= '0;
      in_d_reg <= '0;
    end else begin
      in_m_reg <= IN_CLK;
      in_s_reg <= in_m_reg;
      in_d_reg <= in_s_reg;
    end
  end
  assign in_rise = in_s_reg & ~in_d_reg;
  assign win_end = win_cnt_reg == 16'(WIN_CYC - 1);
  // Measurement window timer
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      win_cnt_reg <= '0;
    end else begin
      win_cnt_reg <= win_end ? 16'h0000 : win_cnt_reg + 16'h0001;
    end
  end
  // Absolute difference of measured and expected counts
  function automatic logic [15:0] trs_dev(input logic [15:0] a, input logic [15:0] b);
    trs_dev = (a > b) ? a - b : b - a;
  endfunction
  // Edge counts judged once per window; input rates are capped by sampling
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      active_reg <= '0;
      hard_reg <= '0;
      soft_reg <= '0;
      for (int i = 0; i < NIN; i++) begin
        edge_cnt_reg[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NIN; i++) begin
        if (win_end) begin
          edge_cnt_reg[i] <= '0;
          active_reg[i] <= (edge_cnt_reg[i] != 16'h0000) | in_rise[i];
          hard_reg[i] <= trs_dev(edge_cnt_reg[i], cfg_reg[i].expect_cnt) > limit_reg[15:0];
          soft_reg[i] <= trs_dev(edge_cnt_reg[i], cfg_reg[i].expect_cnt) > limit_reg[31:16];
        end else if (in_rise[i]) begin
          edge_cnt_reg[i] <= edge_cnt_reg[i] + 16'h0001;
        end
      end
    end
  end
  // Soft excursion is only a warning, never part of validity
  always_comb begin
    for (int i = 0; i < NIN; i++) begin
      valid[i] = (~cfg_reg[i].act_mon | active_reg[i]) &
                 (~cfg_reg[i].freq_mon | ~(hard_reg[i] & active_reg[i]));
    end
  end
  // ----------------------------------------
  // Reference selection
  // ----------------------------------------
  // Returns {found, index}; lowest number is best, ties go to lower index
  function automatic logic [3:0] trs_pick(input logic [4*NIN-1:0] pri, input logic [NIN-1:0] ok);
    logic [3:0] best;
    logic [3:0] res;
    best = 4'hF;
    res = 4'h0;
    for (int i = NIN - 1; i >= 0; i--) begin
      if (ok[i] && pri[4*i+:4] != 4'h0 && pri[4*i+:4] <= best) begin
        best = pri[4*i+:4];
        res = {1'b1, 3'(i)};
      end
    end
    trs_pick = res;
  endfunction
  logic [4*NIN-1:0] pri0_vec, pri4_vec;
  logic [3:0] pick0, pick4;
  always_comb begin
    for (int i = 0; i < NIN; i++) begin
      pri0_vec[4*i+:4] = cfg_reg[i].pri_prim;
      pri4_vec[4*i+:4] = cfg_reg[i].pri_aux;
    end
  end
  assign pick0 = trs_pick(pri0_vec, valid);
  assign pick4 = trs_pick(pri4_vec, valid);
  logic [2:0] t0_sel_reg, t4_sel_reg;
  logic t0_have_reg, t4_have_reg, ref_ok0, ref_ok4;
  assign ref_ok0 = t0_have_reg & valid[t0_sel_reg];
  assign ref_ok4 = t4_have_reg & valid[t4_sel_reg];
  // Primary choice: forcing first, then nonrevertive hold, then priority
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      t0_sel_reg <= '0;
      t0_have_reg <= 1'b0;
    end else if (t0_force_en) begin
      t0_sel_reg <= t0_force_sel;
      t0_have_reg <= 1'b1;
    end else if (nonrev && ref_ok0) begin
      t0_sel_reg <= t0_sel_reg;
    end else begin
      t0_sel_reg <= pick0[3] ? pick0[2:0] : t0_sel_reg;
      t0_have_reg <= pick0[3];
    end
  end
  // Auxiliary choice, always revertive
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      t4_sel_reg <= '0;
      t4_have_reg <= 1'b0;
    end else if (t4_force_en) begin
      t4_sel_reg <= t4_force_sel;
      t4_have_reg <= 1'b1;
    end else begin
      t4_sel_reg <= pick4[3] ? pick4[2:0] : t4_sel_reg;
      t4_have_reg <= pick4[3];
    end
  end
  // ----------------------------------------
  // Path state machines
  // ----------------------------------------
  trs_pkg::trs_t0_state_type t0_state_reg;
  trs_pkg::trs_t4_state_type t4_state_reg;
  // Locking needs one full clean window; loss acts at once
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      t0_state_reg <= trs_pkg::TRS_FREE;
    end else if (t0_man_en) begin
      case (t0_man_code)
        2'd1: t0_state_reg <= trs_pkg::TRS_LOCKED;
        2'd2: t0_state_reg <= trs_pkg::TRS_HOLD;
        default: t0_state_reg <= trs_pkg::TRS_FREE;
      endcase
    end else begin
      case (t0_state_reg)
        trs_pkg::TRS_FREE: begin
          if (ref_ok0 && win_end) begin
            t0_state_reg <= trs_pkg::TRS_LOCKED;
          end
        end
        trs_pkg::TRS_LOCKED: begin
          if (!ref_ok0) begin
            t0_state_reg <= trs_pkg::TRS_HOLD;
          end
        end
        trs_pkg::TRS_HOLD: begin
          if (ref_ok0 && win_end) begin
            t0_state_reg <= trs_pkg::TRS_LOCKED;
          end
        end
        default: t0_state_reg <= trs_pkg::TRS_FREE;
      endcase
    end
  end
  // Auxiliary machine has no software command input
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      t4_state_reg <= trs_pkg::TRS_AUX_IDLE;
    end else begin
      case (t4_state_reg)
        trs_pkg::TRS_AUX_IDLE: begin
          if (ref_ok4 && win_end) begin
            t4_state_reg <= trs_pkg::TRS_AUX_LOCK;
          end
        end
        trs_pkg::TRS_AUX_LOCK: begin
          if (!ref_ok4) begin
            t4_state_reg <= trs_pkg::TRS_AUX_IDLE;
          end
        end
        default: t4_state_reg <= trs_pkg::TRS_AUX_IDLE;
      endcase
    end
  end
  // ----------------------------------------
  // Phase build-out and failure flag
  // ----------------------------------------
  logic [2:0] t0_sel_d_reg;
  logic soft_sel_d_reg, pbo_ev;
  // A reference switch or a soft excursion of the reference counts as a hit
  assign pbo_ev = (t0_sel_reg != t0_sel_d_reg) | (soft_reg[t0_sel_reg] & ~soft_sel_d_reg);
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      t0_sel_d_reg <= '0;
      soft_sel_d_reg <= 1'b0;
      PBO_PULSE <= 1'b0;
      pbo_cnt_reg <= '0;
    end else begin
      t0_sel_d_reg <= t0_sel_reg;
      soft_sel_d_reg <= soft_reg[t0_sel_reg];
      PBO_PULSE <= pbo_ev && t0_state_reg == trs_pkg::TRS_LOCKED;
      if (pbo_ev && t0_state_reg == trs_pkg::TRS_LOCKED) begin
        pbo_cnt_reg <= pbo_cnt_reg + 16'h0001;
      end
    end
  end
  // Set wins over a write-one clear in the same cycle
  assign fail_set = ~ref_ok0;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      fail_flag_reg <= 1'b0;
    end else if (fail_set) begin
      fail_flag_reg <= 1'b1;
    end else if (wr && PADDR == `TRS_FLAG_OFS && PWDATA[`TRS_FLAG_FAIL_BIT]) begin
      fail_flag_reg <= 1'b0;
    end
  end
  assign REF_FAIL_O = fail_flag_reg & pin_en;
  assign REF_FAIL_OE = pin_en;
  // ----------------------------------------
  // Phase measurement and bypass
  // ----------------------------------------
  logic ph_run_reg, byp_clk_reg;
  logic [23:0] ph_cnt_reg;
  logic [3:0] byp_cnt_reg;
  // Counts cycles from an edge of input a to the next edge of input b
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ph_run_reg <= 1'b0;
      ph_cnt_reg <= '0;
      ph_val_reg <= '0;
    end else if (!meas_en) begin
      ph_run_reg <= 1'b0;
    end else if (ph_run_reg && in_rise[meas_b]) begin
      ph_run_reg <= 1'b0;
      ph_val_reg <= ph_cnt_reg;
    end else if (!ph_run_reg && in_rise[meas_a]) begin
      ph_run_reg <= 1'b1;
      ph_cnt_reg <= 24'h000001;
    end else if (ph_run_reg) begin
      ph_cnt_reg <= ph_cnt_reg + 24'h000001;
    end
  end
  // Divided aux reference; toggles every div+1 rising edges
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      byp_cnt_reg <= '0;
      byp_clk_reg <= 1'b0;
    end else if (in_rise[t4_sel_reg]) begin
      if (byp_cnt_reg >= route_reg[22:19]) begin
        byp_cnt_reg <= '0;
        byp_clk_reg <= ~byp_clk_reg;
      end else begin
        byp_cnt_reg <= byp_cnt_reg + 4'h1;
      end
    end
  end
  assign BYPASS_CLK = byp_clk_reg;
  assign BYPASS_EN = route_reg[14:8];
  assign ENGINE_PATH = route_reg[6:0];
  assign AUX_MULT_PATH = route_reg[7];
  // Out-of-range codes clamp to the slowest-end legal setting
  assign T0_BW = (ctrl_reg[16:12] > `TRS_T0_BW_MAX) ? `TRS_T0_BW_MAX : ctrl_reg[16:12];
  assign T4_BW = (ctrl_reg[18:17] > `TRS_T4_BW_MAX) ? `TRS_T4_BW_MAX : ctrl_reg[18:17];
  // ----------------------------------------
  // Frame and multiframe sync
  // ----------------------------------------
  logic [2:0] sy_m_reg, sy_s_reg, sy_d_reg;
  logic [15:0] fs_cnt_reg;
  logic [1:0] quarter_reg, sync_cnt_reg, sync_lim;
  logic sync_rise, fs_wrap;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sy_m_reg <= '0;
      sy_s_reg <= '0;
      sy_d_reg <= '0;
    end else begin
      sy_m_reg <= SYNC_IN;
      sy_s_reg <= sy_m_reg;
      sy_d_reg <= sy_s_reg;
    end
  end
  assign sync_rise = (sync_sel != 2'd0) && sy_s_reg[sync_sel - 2'd1] && !sy_d_reg[sync_sel - 2'd1];
  assign sync_lim = (sync_rate == 2'd0) ? 2'd0 : (sync_rate == 2'd1) ? 2'd1 : 2'd3;
  assign fs_wrap = fs_cnt_reg == 16'(FS_CYC - 1);
  // Every first, second or fourth sync edge, chosen by sync_rate, restarts the multiframe
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      fs_cnt_reg <= '0;
      quarter_reg <= '0;
      sync_cnt_reg <= '0;
    end else if (sync_rise && sync_cnt_reg >= sync_lim) begin
      sync_cnt_reg <= '0;
      fs_cnt_reg <= '0;
      quarter_reg <= '0;
    end else begin
      if (sync_rise) begin
        sync_cnt_reg <= sync_cnt_reg + 2'd1;
      end
      fs_cnt_reg <= fs_wrap ? 16'h0000 : fs_cnt_reg + 16'h0001;
      if (fs_wrap) begin
        quarter_reg <= quarter_reg + 2'd1;
      end
    end
  end
  // Both high in the second half, so falling edges meet at the wrap
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      FRAME_SYNC_OUT <= 1'b0;
      MULTIFRAME_SYNC_OUT <= 1'b0;
    end else begin
      FRAME_SYNC_OUT <= fs_cnt_reg >= 16'(FS_CYC / 2);
      MULTIFRAME_SYNC_OUT <= quarter_reg[1];
    end
  end
  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PRDATA <= '0;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      if (PADDR == `TRS_CTRL_OFS) begin
        PRDATA <= ctrl_reg;
      end else if (PADDR == `TRS_ROUTE_OFS) begin
        PRDATA <= route_reg;
      end else if (PADDR == `TRS_LIMIT_OFS) begin
        PRDATA <= limit_reg;
      end else if (PADDR == `TRS_STAT_OFS) begin
        PRDATA <= {17'h00000, t4_state_reg, t0_state_reg, ref_ok4, ref_ok0,
                   1'b0, t4_sel_reg, 1'b0, t0_sel_reg};
      end else if (PADDR == `TRS_FLAG_OFS) begin
        PRDATA <= {15'h0000, fail_flag_reg, soft_reg, valid};
      end else if (PADDR == `TRS_PHASE_OFS) begin
        PRDATA <= {8'h00, ph_val_reg};
      end else if (PADDR == `TRS_PBO_OFS) begin
        PRDATA <= {16'h0000, pbo_cnt_reg};
      end else if (PADDR[7:5] == 3'b001) begin
        PRDATA <= cfg_reg[PADDR[4:2]];
      end else begin
        PRDATA <= '0;
      end
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  force_sel_a: assert property (@(posedge CLK) disable iff (RST)
    t0_force_en |=> t0_sel_reg == $past(t0_force_sel)) else $error("forced ref not taken");
  auto_pick_a: assert property (@(posedge CLK) disable iff (RST)
    !t0_force_en && !nonrev && pick0[3] |=> t0_sel_reg == $past(pick0[2:0]))
    else $error("best input not selected");
  nonrev_hold_a: assert property (@(posedge CLK) disable iff (RST)
    !t0_force_en && nonrev && ref_ok0 |=> $stable(t0_sel_reg)) else $error("nonrev switched");
  hold_entry_a: assert property (@(posedge CLK) disable iff (RST)
    !t0_man_en && t0_state_reg == trs_pkg::TRS_LOCKED && !ref_ok0
    |=> t0_state_reg == trs_pkg::TRS_HOLD) else $error("no holdover on loss");
  free_stay_a: assert property (@(posedge CLK) disable iff (RST)
    !t0_man_en && t0_state_reg == trs_pkg::TRS_FREE && !ref_ok0
    |=> t0_state_reg == trs_pkg::TRS_FREE) else $error("left free-run without ref");
  fail_set_a: assert property (@(posedge CLK) disable iff (RST)
    !ref_ok0 |=> fail_flag_reg) else $error("failure flag not set");
  fail_pin_a: assert property (@(posedge CLK) disable iff (RST)
    pin_en && $rose(fail_flag_reg) |-> REF_FAIL_O && REF_FAIL_OE) else $error("pin not mirrored");
  bw_range_a: assert property (@(posedge CLK) disable iff (RST)
    T0_BW <= 5'd20 && T4_BW <= 2'd2) else $error("bandwidth code out of range");
  frame_fall_a: assert property (@(posedge CLK) disable iff (RST)
    $fell(MULTIFRAME_SYNC_OUT) |-> $fell(FRAME_SYNC_OUT)) else $error("sync edges apart");
  pbo_pulse_a: assert property (@(posedge CLK) disable iff (RST)
    t0_state_reg == trs_pkg::TRS_LOCKED && t0_sel_reg != t0_sel_d_reg |=> PBO_PULSE)
    else $error("no build-out on switch");
endmodule

// *** tb/trs_line_model.sv ***
// Line-card side model: eight reference clocks and three quiet sync pins.
// Assumes the bench starts and stops each clock through run_en.
`timescale 1ns/1ps
module trs_line_model #(
  parameter int HALF_NS = 30
) (
  // Control from the bench
  input wire logic [7:0] run_en,
  // Pins toward the device
  output logic [7:0] in_clk,
  output logic [2:0] sync_in
);
  // Sync sources absent, so their pins stand still
  assign sync_in = 3'h0;
  // Distinct rates per input; a stopped source stands low, like a dead line
  for (genvar i = 0; i < 8; i++) begin : g_src
    initial in_clk[i] = 1'b0;
    always begin
      if (run_en[i]) begin
        #(HALF_NS + 7 * i) in_clk[i] = ~in_clk[i];
      end else begin
        in_clk[i] = 1'b0;
        @(run_en[i]);
      end
    end
  end
endmodule

// *** tb/trs_top_tb.sv ***
// Self-checking bench of the reference selector, with random routing values.
// Assumes the line model drives the clock pins and APB has zero wait states.
`timescale 1ns/1ps
`include "trs_defines.svh"
module trs_top_tb;
  // Short windows and frames keep the run brief
  localparam int FS = 100;
  localparam int WIN = 20;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [7:0] paddr = 8'h00, run_en = 8'h00, in_clk;
  logic [31:0] pwdata = 32'h0, prdata, q, v, seed = 32'd73121;
  logic [2:0] sync_in;
  logic ref_fail_o, ref_fail_oe, fs, mf, aux_mult, byp_clk, pbo;
  logic [6:0] eng, byp;
  logic [4:0] t0_bw;
  logic [1:0] t4_bw;
  int n_fail = 0, tests_run = 0, n;
  // ----------------------------------------
  // Device, far side and clock
  // ----------------------------------------
  trs_top #(.FS_CYC(FS), .WIN_CYC(WIN)) uut (.CLK(clk), .RST(rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .IN_CLK(in_clk), .SYNC_IN(sync_in),
    .REF_FAIL_O(ref_fail_o), .REF_FAIL_OE(ref_fail_oe), .FRAME_SYNC_OUT(fs),
    .MULTIFRAME_SYNC_OUT(mf), .ENGINE_PATH(eng), .AUX_MULT_PATH(aux_mult), .BYPASS_EN(byp),
    .BYPASS_CLK(byp_clk), .T0_BW(t0_bw), .T4_BW(t4_bw), .PBO_PULSE(pbo));
  trs_line_model model (.run_en(run_en), .in_clk(in_clk), .sync_in(sync_in));
  always #5 clk = ~clk;
  // Random source and expected-value helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] cfg(input logic [3:0] p, input logic [3:0] a);
    trs_pkg::trs_incfg_type c;
    c = '0;
    c.act_mon = 1'b1;
    c.pri_aux = a;
    c.pri_prim = p;
    return c;
  endfunction
  // Compare, count and report
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 100);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Waits low, then high, then counts the high cycles of a frame output
  task automatic hi_len(input bit m);
    for (int p = 0; p < 3; p++) begin
      n = 0;
      while ((m ? mf : fs) === (p != 1) && n < 1000) begin
        @(posedge clk);
        n++;
      end
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Watchdog: the whole sequence needs about a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    $display("unexpected watchdog expected finish seen hang");
    summarize();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    apb(0, `TRS_LIMIT_OFS, 0); chk("limit", 32'h0004_0010, q);
    for (int i = 0; i < 8; i++) begin
      apb(0, `TRS_INCFG_OFS + 8'(4 * i), 0); chk("incfg", cfg(4'(i + 1), 4'(i + 1)), q);
    end
    apb(0, 8'h1C, 0); chk("unmapped", 32'h0, q);
    chk("slverr", 32'h1, {31'h0, err});
    $display("test reset done");
    // Routing and bandwidth; first pass takes the all-ones corner
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 32'hFFFF_FFFF : xs();
      apb(1, `TRS_ROUTE_OFS, v & 32'h007F_FFFF);
      apb(1, `TRS_CTRL_OFS, (v & 32'h0007_F000) | 32'h0008_0000);
      // Let the control write settle before sampling its outputs
      @(posedge clk);
      chk("engine", v[6:0], eng);
      chk("aux_mult", v[7], aux_mult);
      chk("bypass", v[14:8], byp);
      chk("t0_bw", (v[16:12] > 5'd20) ? 5'd20 : v[16:12], t0_bw);
      chk("t4_bw", (v[18:17] > 2'd2) ? 2'd2 : v[18:17], t4_bw);
      chk("fail_pin", 2'b11, {ref_fail_oe, ref_fail_o});
    end
    $display("test routing done");
    // Inputs 2 and 5 alive; best priority wins, per path
    run_en <= 8'h24;
    repeat (4 * WIN + 10) @(posedge clk);
    apb(0, `TRS_STAT_OFS, 0); chk("stat_lock", 32'h0000_0B22, q & 32'h0000_1F77);
    apb(1, `TRS_INCFG_OFS + 8'h08, cfg(0, 3));
    repeat (3) @(posedge clk);
    apb(0, `TRS_STAT_OFS, 0); chk("sel_unavail", 32'h25, q & 32'h77);
    apb(1, `TRS_INCFG_OFS + 8'h08, cfg(1, 3));
    apb(1, `TRS_INCFG_OFS + 8'h14, cfg(1, 6));
    repeat (3) @(posedge clk);
    apb(0, `TRS_STAT_OFS, 0); chk("sel_tie", 32'h22, q & 32'h77);
    apb(1, `TRS_CTRL_OFS, 32'h0008_000F);
    repeat (3) @(posedge clk);
    apb(0, `TRS_STAT_OFS, 0); chk("sel_force", 32'h7, q & 32'h7);
    apb(1, `TRS_CTRL_OFS, 32'h0008_0000);
    repeat (2 * WIN) @(posedge clk);
    apb(1, `TRS_FLAG_OFS, 32'h0001_0000);
    apb(0, `TRS_FLAG_OFS, 0); chk("flag_clr", 0, q[16]);
    chk("pin_clr", 0, ref_fail_o);
    $display("test select done");
    // All references lost after lock: holdover and failure raised
    run_en <= 8'h00;
    repeat (3 * WIN + 10) @(posedge clk);
    apb(0, `TRS_STAT_OFS, 0); chk("hold", 3'b100, q[12:10]);
    chk("pin_fail", 1, ref_fail_o);
    $display("test holdover done");
    hi_len(0); chk("frame_high", FS / 2, n);
    hi_len(1); chk("multi_high", 2 * FS, n);
    $display("test frame done");
    summarize();
  end
endmodule
